// [design/cpc_config_top.sv]
`timescale 1ns/1ns
module cpc_config_top #(
   parameter int TW_QUAL_CYCLES    = cpc_pkg::CPC_TW_QUAL_CYCLES,
   parameter int RECOV_UNIT_CYCLES = cpc_pkg::CPC_RECOV_UNIT_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic      [7:0]  reg_rdata_o,
   input  wire logic        thermal_warning_n_i,
   input  wire logic        fault_n_i,
   input  wire logic [15:0] fault_recovery_time_const_i,
   input  wire logic [23:0] thermal_post_scale_i,
   input  wire logic [23:0] unity_scale_i,
   output logic      [7:0]  post_scale_addr_o,
   output logic      [2:0]  pll_ratio_select_o,
   output logic      [1:0]  interp_ratio_o,
   output logic      [9:0]  mclk_ratio_o,
   output logic             thermal_atten_o,
   output logic      [23:0] out_scale_o,
   output logic             stage_tristate_o,
   output logic             fault_latched_o
);
   import cpc_pkg::*;

   // ==========================================================
   // Parameter checks.
   // ==========================================================
   if (TW_QUAL_CYCLES < 2 || TW_QUAL_CYCLES > 32'h7fffffff) begin : g_chk_tw
      $error("TW_QUAL_CYCLES out of range");
   end
   if (RECOV_UNIT_CYCLES < 1 || RECOV_UNIT_CYCLES > 65536) begin : g_chk_ru
      $error("RECOV_UNIT_CYCLES out of range");
   end

   localparam logic [31:0] TW_LAST = 32'(TW_QUAL_CYCLES - 1);
   localparam logic [15:0] RU_LAST = 16'(RECOV_UNIT_CYCLES - 1);

   logic [7:0]  cfg_reg;
   logic [31:0] tw_cnt_reg;
   logic        atten_reg;
   logic [15:0] unit_cnt_reg;
   logic [15:0] tick_cnt_reg;
   logic [15:0] recov_len;
   logic        recov_done;
   cpc_fstate_t fstate_reg;

   wire logic adj_bp   = cfg_reg[CPC_TW_ADJ_BP];
   wire logic recov_bp = cfg_reg[CPC_TW_RECOV_BP];
   wire logic fault_bp = cfg_reg[CPC_FAULT_BP];

   // ==========================================================
   // Register access.
   // ==========================================================
   // Configuration register; only offset zero is writable here.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg <= CPC_CFG_RESET;
      end else if (ce_i && reg_wr_i && reg_addr_i == CPC_ADDR_CFG) begin
         cfg_reg <= reg_wdata_i;
      end
   end

   // Read data is registered, one cycle after the read strobe.
   // Unmapped offsets read zero so software sees no stale data.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (ce_i && reg_rd_i) begin
         if (reg_addr_i == CPC_ADDR_CFG) begin
            reg_rdata_o <= cfg_reg;
         end else if (reg_addr_i == CPC_ADDR_STATUS) begin
            reg_rdata_o <= 8'h00;
            reg_rdata_o[CPC_ST_WARN]  <= ~thermal_warning_n_i;
            reg_rdata_o[CPC_ST_FAULT] <= fstate_reg != CPC_FS_RUN;
         end else begin
            reg_rdata_o <= 8'h00;
         end
      end
   end

   // ==========================================================
   // Clock ratio and interpolation.
   // ==========================================================
   // The master clock multiple halves when the first stage no longer
   // oversamples, since the internal rate stays fixed.
   function automatic logic [9:0] ratio_f(input logic [2:0] sel,
                                          input logic [1:0] ir);
      logic [9:0] r;
      r = CPC_RATIO_000;
      if (sel[2]) begin
         r = CPC_RATIO_1XX;
      end else begin
         case (sel[1:0])
            2'h3:    r = CPC_RATIO_011;
            2'h2:    r = CPC_RATIO_010;
            2'h1:    r = CPC_RATIO_001;
            default: r = CPC_RATIO_000;
         endcase
      end
      ratio_f = (ir == CPC_IR_2X) ? r : (r >> 1);
   endfunction

   // Clock controls follow the register with one cycle of latency.
   // The code 11 for the interpolation field is reserved and is served
   // like the halved ratios; the PLL is not guarded against it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pll_ratio_select_o <= CPC_CFG_RESET[CPC_PLL_MSB:CPC_PLL_LSB];
         interp_ratio_o     <= CPC_CFG_RESET[CPC_IR_MSB:CPC_IR_LSB];
         mclk_ratio_o       <= ratio_f(CPC_CFG_RESET[CPC_PLL_MSB:CPC_PLL_LSB],
                                       CPC_CFG_RESET[CPC_IR_MSB:CPC_IR_LSB]);
      end else if (ce_i) begin
         pll_ratio_select_o <= cfg_reg[CPC_PLL_MSB:CPC_PLL_LSB];
         interp_ratio_o     <= cfg_reg[CPC_IR_MSB:CPC_IR_LSB];
         mclk_ratio_o       <= ratio_f(cfg_reg[CPC_PLL_MSB:CPC_PLL_LSB],
                                       cfg_reg[CPC_IR_MSB:CPC_IR_LSB]);
      end
   end

   // ==========================================================
   // Thermal warning attenuation.
   // ==========================================================
   // Qualification timer counts only a continuous warning.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tw_cnt_reg <= 32'h0;
      end else if (ce_i) begin
         if (thermal_warning_n_i || adj_bp) begin
            tw_cnt_reg <= 32'h0;
         end else if (tw_cnt_reg != TW_LAST) begin
            tw_cnt_reg <= tw_cnt_reg + 32'h1;
         end
      end
   end

   // Attenuation sets after the full interval and clears on release
   // unless recovery is bypassed.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         atten_reg <= 1'b0;
      end else if (ce_i) begin
         if (adj_bp) begin
            atten_reg <= 1'b0;
         end else if (!thermal_warning_n_i && tw_cnt_reg == TW_LAST) begin
            atten_reg <= 1'b1;
         end else if (thermal_warning_n_i && !recov_bp) begin
            atten_reg <= 1'b0;
         end
      end
   end

   // The scale is held in coefficient memory so software can retune it.
   assign post_scale_addr_o = CPC_POST_SCALE_ADDR;
   assign thermal_atten_o   = atten_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_scale_o <= 24'h0;
      end else if (ce_i) begin
         out_scale_o <= atten_reg ? thermal_post_scale_i : unity_scale_i;
      end
   end

   // ==========================================================
   // Fault shutdown and recovery.
   // ==========================================================
   // Zero or oversized constants are clamped to the legal range.
   always_comb begin
      recov_len = fault_recovery_time_const_i;
      if (recov_len == 16'h0) begin
         recov_len = 16'h1;
      end else if (recov_len > CPC_RECOV_MAX) begin
         recov_len = CPC_RECOV_MAX;
      end
   end

   assign recov_done = unit_cnt_reg == RU_LAST && tick_cnt_reg >= recov_len - 16'h1;

   // Period counter runs only while the stage is held off.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unit_cnt_reg <= 16'h0;
         tick_cnt_reg <= 16'h0;
      end else if (ce_i) begin
         if (fstate_reg != CPC_FS_SHUT || recov_done) begin
            unit_cnt_reg <= 16'h0;
            tick_cnt_reg <= 16'h0;
         end else if (unit_cnt_reg == RU_LAST) begin
            unit_cnt_reg <= 16'h0;
            tick_cnt_reg <= tick_cnt_reg + 16'h1;
         end else begin
            unit_cnt_reg <= unit_cnt_reg + 16'h1;
         end
      end
   end

   // Recovery loop: hold off, release for one retest cycle, repeat.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fstate_reg <= CPC_FS_RUN;
      end else if (ce_i) begin
         case (fstate_reg)
            CPC_FS_RUN: begin
               if (!fault_n_i) begin
                  fstate_reg <= fault_bp ? CPC_FS_LATCH : CPC_FS_SHUT;
               end
            end
            CPC_FS_SHUT: begin
               if (fault_bp) begin
                  fstate_reg <= CPC_FS_LATCH;
               end else if (recov_done) begin
                  fstate_reg <= CPC_FS_RETEST;
               end
            end
            CPC_FS_RETEST: begin
               fstate_reg <= fault_n_i ? CPC_FS_RUN : CPC_FS_SHUT;
            end
            CPC_FS_LATCH: begin
               fstate_reg <= CPC_FS_LATCH;
            end
            default: begin
               fstate_reg <= CPC_FS_SHUT;
            end
         endcase
      end
   end

   // The fault path is combinational so the stage drops without a cycle
   // of delay; it also overrides the clock enable for safety.
   assign stage_tristate_o = !fault_n_i || fstate_reg == CPC_FS_SHUT
                             || fstate_reg == CPC_FS_LATCH;
   assign fault_latched_o  = fstate_reg == CPC_FS_LATCH;

   // ==========================================================
   // Assertions.
   // ==========================================================
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Registered outputs are checked one edge after their cause, so most
   // antecedents name ce_i; a frozen block would otherwise trip them.
   AST_FAULT_OFF: assert property (!fault_n_i |-> stage_tristate_o)
      else $error("Stage not disabled on fault");
   AST_LATCH_HOLD: assert property (fault_latched_o
                                    |=> fault_latched_o && stage_tristate_o)
      else $error("Latched shutdown released");
   AST_ATTEN_QUAL: assert property ($rose(atten_reg) |-> $past(tw_cnt_reg) == TW_LAST)
      else $error("Attenuation without full qualification");
   AST_ADJ_BYPASS: assert property (ce_i && adj_bp |=> !atten_reg)
      else $error("Attenuation while adjustment bypassed");
   AST_RECOVER: assert property (ce_i && atten_reg && thermal_warning_n_i && !recov_bp
                                 |=> !atten_reg)
      else $error("Attenuation not removed on release");
   AST_KEEP: assert property (ce_i && atten_reg && !adj_bp && recov_bp |=> atten_reg)
      else $error("Attenuation dropped while recovery bypassed");
   AST_RESTART: assert property (ce_i && thermal_warning_n_i |=> tw_cnt_reg == 32'h0)
      else $error("Qualification timer not restarted");
   AST_RATIO_256: assert property (ce_i && cfg_reg[4:0] == 5'h03
                                   |=> mclk_ratio_o == 10'h100)
      else $error("Wrong ratio for 011 with 2x");
   AST_RATIO_64: assert property (ce_i && cfg_reg[4:2] == 3'h3
                                  |=> mclk_ratio_o == 10'h040)
      else $error("Wrong ratio for 1xx with pass-through");
   AST_IR_OUT: assert property (ce_i |=> interp_ratio_o == $past(cfg_reg[4:3]))
      else $error("Interpolation output does not follow register");
   AST_PERIOD: assert property ($rose(fstate_reg == CPC_FS_RETEST) |-> $past(recov_done))
      else $error("Retest before recovery period elapsed");
   AST_RETEST: assert property (ce_i && fstate_reg == CPC_FS_RETEST && !fault_n_i
                                |=> fstate_reg == CPC_FS_SHUT)
      else $error("Persistent fault not retried");
   AST_PLL_OUT: assert property (ce_i |=> pll_ratio_select_o == $past(cfg_reg[2:0]))
      else $error("Clock select output does not follow register");
   AST_SCALE: assert property (ce_i |=> out_scale_o == ($past(atten_reg) ?
                               $past(thermal_post_scale_i) : $past(unity_scale_i)))
      else $error("Output scale does not follow attenuation");
   AST_LATCH_ENTRY: assert property (ce_i && fault_bp && !fault_n_i && fstate_reg == CPC_FS_RUN
                                     |=> fault_latched_o)
      else $error("Fault with recovery bypassed did not latch");

   // Covers mark the main scenarios that the bench is expected to reach.
   COV_ATTEN: cover property ($rose(atten_reg));
   COV_RETRY: cover property (fstate_reg == CPC_FS_RETEST ##1 fstate_reg == CPC_FS_SHUT);
   COV_RECOVERED: cover property (fstate_reg == CPC_FS_RETEST ##1 fstate_reg == CPC_FS_RUN);
   COV_LATCH: cover property ($rose(fault_latched_o));
endmodule

// [design/cpc_pkg.sv]
package cpc_pkg;
   // ==========================================================
   // Register map.
   // ==========================================================
   localparam logic [7:0] CPC_ADDR_CFG    = 8'h00;
   localparam logic [7:0] CPC_ADDR_STATUS = 8'h2d;
   localparam logic [7:0] CPC_CFG_RESET   = 8'h63;

   // Field positions of the clock and protection register.
   localparam int CPC_PLL_LSB     = 0;
   localparam int CPC_PLL_MSB     = 2;
   localparam int CPC_IR_LSB      = 3;
   localparam int CPC_IR_MSB      = 4;
   localparam int CPC_TW_RECOV_BP = 5;
   localparam int CPC_TW_ADJ_BP   = 6;
   localparam int CPC_FAULT_BP    = 7;

   // Status register bit positions.
   localparam int CPC_ST_WARN  = 0;
   localparam int CPC_ST_FAULT = 1;

   // Interpolation ratio codes.
   localparam logic [1:0] CPC_IR_2X   = 2'h0;
   localparam logic [1:0] CPC_IR_PASS = 2'h1;
   localparam logic [1:0] CPC_IR_DOWN = 2'h2;

   // Master clock multiples of fs with 2x oversampling selected.
   localparam logic [9:0] CPC_RATIO_1XX = 10'h080;
   localparam logic [9:0] CPC_RATIO_011 = 10'h100;
   localparam logic [9:0] CPC_RATIO_010 = 10'h180;
   localparam logic [9:0] CPC_RATIO_001 = 10'h200;
   localparam logic [9:0] CPC_RATIO_000 = 10'h300;

   // Coefficient memory location of the thermal post-scale value.
   localparam logic [7:0] CPC_POST_SCALE_ADDR = 8'h37;

   // ==========================================================
   // Timing.
   // ==========================================================
   localparam int CPC_CLK_MHZ          = 250;
   localparam int CPC_TW_QUAL_MS       = 400;
   localparam int CPC_TW_QUAL_CYCLES   = CPC_TW_QUAL_MS * 1000 * CPC_CLK_MHZ;
   localparam int CPC_RECOV_UNIT_US    = 100;
   localparam int CPC_RECOV_UNIT_CYCLES = CPC_RECOV_UNIT_US * CPC_CLK_MHZ;
   localparam logic [15:0] CPC_RECOV_MAX = 16'h2710;

   // Fault recovery state machine.
   typedef enum logic [3:0] {
      CPC_FS_RUN    = 4'b0001,
      CPC_FS_SHUT   = 4'b0010,
      CPC_FS_RETEST = 4'b0100,
      CPC_FS_LATCH  = 4'b1000
   } cpc_fstate_t;
endpackage

// [testbench/cpc_stage_model.sv]
`timescale 1ns/1ns
// ==========================================================
// Output stage model: drives the warning and fault lines.
// ==========================================================
module cpc_stage_model (
   input  wire logic clk_i,
   input  wire logic warn_req_i,
   input  wire logic fault_req_i,
   input  wire logic stage_tristate_i,
   output logic      thermal_warning_n_o,
   output logic      fault_n_o
);
   // Both lines are active low levels; they follow the requests without delay.
   assign thermal_warning_n_o = !warn_req_i;
   // The fault stays low while requested, even during a retest window.
   assign fault_n_o = !fault_req_i;
   // Count disabled clock cycles, which shows the stage really went off.
   int off_cycles = 0;
   always @(posedge clk_i) begin
      if (stage_tristate_i) begin
         off_cycles <= off_cycles + 1;
      end
   end
endmodule

// [testbench/tb_cpc_config_top.sv]
`timescale 1ns/1ns
`define CHK(nm, ex, ac) begin total_checks++; if ((ac) !== (ex)) begin miscompares++; \
   $display("wrong value %s exp %h got %h", nm, ex, ac); end end
module tb_cpc_config_top;
   import cpc_pkg::*;
   localparam int QUAL = 16;
   localparam int UNIT = 4;
   logic        clk_i = 0, rst_i = 1, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
   logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, post_scale_addr_o;
   logic        warn_req = 0, fault_req = 0, thermal_warning_n_i, fault_n_i;
   logic [15:0] recov_const = 16'h0002;
   logic [23:0] post_scale = 24'h2d6a86, unity = 24'h400000, out_scale_o;
   logic [2:0]  pll_ratio_select_o;
   logic [1:0]  interp_ratio_o;
   logic [9:0]  mclk_ratio_o, exp_ratio;
   logic        thermal_atten_o, stage_tristate_o, fault_latched_o;
   int          miscompares = 0, total_checks = 0, n, n0;
   // ==========================================================
   // Clock, device and output stage.
   // ==========================================================
   // A steady 250 MHz master clock keeps a whole fs multiple.
   initial forever #2 clk_i = !clk_i;
   cpc_config_top #(.TW_QUAL_CYCLES(QUAL), .RECOV_UNIT_CYCLES(UNIT)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .thermal_warning_n_i(thermal_warning_n_i), .fault_n_i(fault_n_i),
      .fault_recovery_time_const_i(recov_const), .thermal_post_scale_i(post_scale),
      .unity_scale_i(unity), .post_scale_addr_o(post_scale_addr_o),
      .pll_ratio_select_o(pll_ratio_select_o), .interp_ratio_o(interp_ratio_o),
      .mclk_ratio_o(mclk_ratio_o), .thermal_atten_o(thermal_atten_o),
      .out_scale_o(out_scale_o), .stage_tristate_o(stage_tristate_o),
      .fault_latched_o(fault_latched_o));
   cpc_stage_model i_stage (.clk_i(clk_i), .warn_req_i(warn_req), .fault_req_i(fault_req),
      .stage_tristate_i(stage_tristate_o), .thermal_warning_n_o(thermal_warning_n_i),
      .fault_n_o(fault_n_i));
   // ==========================================================
   // Access tasks.
   // ==========================================================
   // Single byte write; derived outputs are given two edges to settle.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i) begin reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= d; end
      @(posedge clk_i) reg_wr_i <= 0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] ex);
      @(posedge clk_i) begin reg_rd_i <= 1; reg_addr_i <= a; end
      @(posedge clk_i) reg_rd_i <= 0;
      #1 `CHK("read data", ex, reg_rdata_o)
   endtask
   // Hold the warning low for a number of edges, then release it.
   task automatic warn(input int cyc);
      @(posedge clk_i) warn_req <= 1;
      repeat (cyc) @(posedge clk_i);
      warn_req <= 0;
      #1;
   endtask
   task automatic stop_test;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Generous limit: the sequence needs well under two thousand cycles.
   initial begin
      #40000;
      miscompares++;
      stop_test();
   end
   // ==========================================================
   // Test sequence.
   // ==========================================================
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      #1 `CHK("pll reset", 3'h3, pll_ratio_select_o)
      `CHK("ratio reset", 10'h100, mclk_ratio_o)
      rd(8'h00, 8'h63);
      // Every select code against each documented interpolation code.
      for (int ir = 0; ir < 3; ir++) begin
         for (int m = 0; m < 8; m++) begin
            wr(8'h00, 8'(ir * 8 + m));
            exp_ratio = m[2] ? 10'h080 : m == 3 ? 10'h100 : m == 2 ? 10'h180 :
                        m == 1 ? 10'h200 : 10'h300;
            if (ir != 0) exp_ratio = exp_ratio >> 1;
            `CHK("pll select", 3'(m), pll_ratio_select_o)
            `CHK("interp", 2'(ir), interp_ratio_o)
            `CHK("mclk ratio", exp_ratio, mclk_ratio_o)
         end
      end
      // Writes elsewhere or with the enable low are ignored; unmapped reads give zero.
      wr(8'h01, 8'hff);
      @(posedge clk_i) ce_i <= 0;
      wr(8'h00, 8'h55);
      @(posedge clk_i) ce_i <= 1;
      rd(8'h00, 8'h17);
      rd(8'h07, 8'h00);
      `CHK("coef addr", 8'h37, post_scale_addr_o)
      // Adjustment bypassed: a long warning leaves the level alone.
      wr(8'h00, 8'h43);
      warn(QUAL + 4);
      `CHK("atten bypassed", 1'b0, thermal_atten_o)
      // Adjustment on: an interrupted warning restarts qualification.
      wr(8'h00, 8'h03);
      warn(QUAL - 4);
      warn(QUAL - 4);
      `CHK("atten early", 1'b0, thermal_atten_o)
      @(posedge clk_i) warn_req <= 1;
      repeat (QUAL + 2) @(posedge clk_i);
      #1 `CHK("atten on", 1'b1, thermal_atten_o)
      rd(8'h2d, 8'h01);
      `CHK("scale atten", post_scale, out_scale_o)
      @(posedge clk_i) warn_req <= 0;
      repeat (3) @(posedge clk_i);
      #1 `CHK("atten removed", 1'b0, thermal_atten_o)
      `CHK("scale unity", unity, out_scale_o)
      // Recovery bypassed: attenuation stays until the bit is cleared.
      wr(8'h00, 8'h23);
      warn(QUAL + 2);
      repeat (10) @(posedge clk_i);
      #1 `CHK("atten kept", 1'b1, thermal_atten_o)
      wr(8'h00, 8'h03);
      `CHK("atten cleared", 1'b0, thermal_atten_o)
      // One-cycle fault: stage off at once, then one recovery period.
      @(posedge clk_i) fault_req <= 1;
      #1 `CHK("tristate now", 1'b1, stage_tristate_o)
      n0 = i_stage.off_cycles;
      @(posedge clk_i) fault_req <= 0;
      n = 0;
      #1 while (stage_tristate_o === 1'b1 && n < 100) begin
         n++;
         @(posedge clk_i);
         #1;
      end
      `CHK("recovery period", 2 * UNIT, n)
      `CHK("off cycles", 2 * UNIT + 1, i_stage.off_cycles - n0)
      // Persistent fault: retests repeat, then the stage recovers.
      @(posedge clk_i) fault_req <= 1;
      repeat (30) @(posedge clk_i);
      rd(8'h2d, 8'h02);
      `CHK("stage off", 1'b1, stage_tristate_o)
      @(posedge clk_i) fault_req <= 0;
      repeat (2 * UNIT + 4) @(posedge clk_i);
      #1 `CHK("recovered", 1'b0, stage_tristate_o)
      rd(8'h2d, 8'h00);
      // Recovery bypassed: a fault latches shutdown until reset.
      wr(8'h00, 8'h83);
      @(posedge clk_i) fault_req <= 1;
      @(posedge clk_i) fault_req <= 0;
      repeat (40) @(posedge clk_i);
      #1 `CHK("latched", 1'b1, fault_latched_o)
      `CHK("latched off", 1'b1, stage_tristate_o)
      @(posedge clk_i) rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      #1 `CHK("unlatched", 1'b0, fault_latched_o)
      `CHK("stage on", 1'b0, stage_tristate_o)
      rd(8'h00, 8'h63);
      stop_test();
   end
endmodule
